// [rtl/pad_multiplexer.sv]
// Pad multiplexer with fixed-function overrides and the gpio port.
// Assumes pad inputs synchronous to sys_clk_i; tri-state resolved outside.
//
// Contract
// R1 - Software routes every flexible peripheral signal to any configurable pad.
// R2 - Enabled special functions use only their fixed pads.
// R3 - Thirty-four configurable pads 0-7, 9-34; pad 8 is test mode only.
// R4 - I2S, the 1.28 MHz clock and dmic output are also mappable.
// R5 - Out of reset with nothing selected, pads 0-3 carry debug port.
// R6 - Analog enable connects pads 11-15 and 18-20 to analog lines.
// R7 - Analog lines 0-4 and 9 feed converter inputs when enabled.
// R8 - Analog lines 7 and 8 feed amplifier inputs when enabled.
// R9 - Debug port: data out 0, data in 1, mode 2, clock 3.
// R10 - By default pads connect to the gpio port, bits 22 to 0.
// R11 - Per-pin direction; inputs readable, outputs writable.
// R12 - All pins debounce and wake; only 18 pins interrupt.
// R13 - Per-pin pull-up or pull-down selection.
// R14 - A special function wins over a software selection on one pad.
`timescale 1ns/10ps
module pad_multiplexer
   import pad_mux_pkg::*;
#(
   parameter int HOLD_CYC = DEBOUNCE_CYC
) (
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_b_i,
   // Pad side
   input  wire logic [PAD_SLOTS-1:0]         pad_in_i,
   output logic      [PAD_SLOTS-1:0]         pad_out_o,
   output logic      [PAD_SLOTS-1:0]         pad_oe_o,
   output logic      [PAD_SLOTS-1:0]         pad_pull_up_o,
   output logic      [PAD_SLOTS-1:0]         pad_pull_dn_o,
   output logic      [PAD_SLOTS-1:0]         pad_analog_o,
   input  wire logic                         test_mode_pad_i,
   output logic                              test_mode_o,
   // Pad selection per pad slot
   input  wire logic [PAD_SLOTS*SEL_WIDTH-1:0] pad_sel_i,
   // Special function enables
   input  wire logic                         dbg_en_i,
   input  wire logic                         analog_en_i,
   input  wire logic                         gpio_en_i,
   input  wire logic                         kscan_en_i,
   // Flexible peripheral side
   input  wire logic [FLEX_SIGNALS-1:0]      flex_out_i,
   input  wire logic [FLEX_SIGNALS-1:0]      flex_oe_i,
   output logic      [FLEX_SIGNALS-1:0]      flex_in_o,
   input  wire logic                         mic_clk_en_i,
   // Debug port side
   input  wire logic                         dbg_dout_i,
   input  wire logic                         dbg_dout_oe_i,
   output logic                              dbg_din_o,
   output logic                              dbg_mode_o,
   output logic                              dbg_clk_o,
   // Key matrix scan side
   input  wire logic [GPIO_WIDTH-1:0]        key_matrix_column_output_i,
   output logic      [GPIO_WIDTH-1:0]        key_matrix_row_input_o,
   // Analog side
   output logic      [ANA_LINES-1:0]         adc_line_en_o,
   output logic      [ANA_LINES-1:0]         pga_line_en_o,
   // Gpio port
   input  wire logic [GPIO_WIDTH-1:0]        gpio_dir_out_i,
   input  wire logic [GPIO_WIDTH-1:0]        gpio_data_out_i,
   output logic      [GPIO_WIDTH-1:0]        gpio_data_in_o,
   input  wire logic [GPIO_WIDTH-1:0]        gpio_pull_en_i,
   input  wire logic [GPIO_WIDTH-1:0]        gpio_pull_up_i,
   input  wire logic [GPIO_WIDTH-1:0]        gpio_deb_en_i,
   input  wire logic [2*GPIO_WIDTH-1:0]      gpio_wake_mode_i,
   output logic                              wake_o,
   input  wire logic [2*IRQ_PINS-1:0]        gpio_irq_mode_i,
   input  wire logic [IRQ_PINS-1:0]          gpio_irq_clr_i,
   output logic      [IRQ_PINS-1:0]          gpio_irq_status_o
);

   logic [GPIO_WIDTH-1:0] deb_level;
   logic [GPIO_WIDTH-1:0] deb_rise;
   logic [GPIO_WIDTH-1:0] deb_fall;
   logic [GPIO_WIDTH-1:0] raw_bit;
   logic [IRQ_PINS-1:0]   irq_ff;
   logic [IRQ_PINS-1:0]   nxt_irq;
   logic                  wake_ff;
   logic                  nxt_wake;
   logic [7:0]            mic_cnt_ff;
   logic [7:0]            nxt_mic_cnt;
   logic                  mic_clk_ff;
   logic                  nxt_mic_clk;
   logic [FLEX_SIGNALS-1:0] flex_drv;
   logic [PAD_SLOTS-1:0]  nxt_out;
   logic [PAD_SLOTS-1:0]  nxt_oe;
   logic [PAD_SLOTS-1:0]  nxt_pu;
   logic [PAD_SLOTS-1:0]  nxt_pd;
   logic [PAD_SLOTS-1:0]  nxt_ana;
   logic [PAD_SLOTS-1:0]  out_ff;
   logic [PAD_SLOTS-1:0]  oe_ff;
   logic [PAD_SLOTS-1:0]  pu_ff;
   logic [PAD_SLOTS-1:0]  pd_ff;
   logic [PAD_SLOTS-1:0]  ana_ff;
   logic [FLEX_SIGNALS-1:0] nxt_flex_in;
   logic [FLEX_SIGNALS-1:0] flex_in_ff;
   logic                  nxt_din;
   logic                  nxt_mode;
   logic                  nxt_tck;
   logic                  din_ff;
   logic                  mode_ff;
   logic                  tck_ff;
   logic [GPIO_WIDTH-1:0] nxt_row;
   logic [GPIO_WIDTH-1:0] row_ff;
   logic                  dbg_active;

   // Debug port holds pads 0-3 by default
   assign dbg_active = dbg_en_i | ~(gpio_en_i | kscan_en_i | analog_en_i); // R5

   // Gpio bit view of the pads
   always_comb begin
      raw_bit = '0;
      for (int s = 0; s < PAD_SLOTS; s++) begin
         if (slot_to_bit(s) >= 0) begin
            raw_bit[slot_to_bit(s)] = pad_in_i[s];
         end
      end
   end

   // Debounce every port pin
   for (genvar b = 0; b < GPIO_WIDTH; b++) begin : g_deb
      gpio_debounce #(
         .HOLD_CYC (HOLD_CYC)
      ) u_deb (
         .sys_clk_i (sys_clk_i),
         .rst_b_i   (rst_b_i),
         .deb_en_i  (gpio_deb_en_i[b]), // R12
         .raw_i     (raw_bit[b]),
         .level_o   (deb_level[b]),
         .rise_o    (deb_rise[b]),
         .fall_o    (deb_fall[b])
      );
   end

   assign gpio_data_in_o = deb_level; // R11

   // Wake on any pin, sticky interrupt on the first pins only
   always_comb begin
      edge_mode_type m;
      m        = EDGE_OFF;
      nxt_wake = 1'b0;
      nxt_irq  = irq_ff & ~gpio_irq_clr_i;
      for (int b = 0; b < GPIO_WIDTH; b++) begin
         m = edge_mode_type'(gpio_wake_mode_i[2*b +: 2]);
         if ((m[0] & deb_rise[b]) | (m[1] & deb_fall[b])) begin
            nxt_wake = 1'b1; // R12
         end
      end
      for (int b = 0; b < IRQ_PINS; b++) begin
         m = edge_mode_type'(gpio_irq_mode_i[2*b +: 2]);
         if ((m[0] & deb_rise[b]) | (m[1] & deb_fall[b])) begin
            nxt_irq[b] = 1'b1; // R12
         end
      end
   end

   // Mic clock divider
   always_comb begin
      nxt_mic_cnt = mic_cnt_ff + 1'b1;
      nxt_mic_clk = mic_clk_ff;
      if (!mic_clk_en_i) begin
         nxt_mic_cnt = '0;
         nxt_mic_clk = 1'b0;
      end else if (mic_cnt_ff == 8'(MIC_HALF_DIV - 1)) begin
         nxt_mic_cnt = '0;
         nxt_mic_clk = ~mic_clk_ff; // R4
      end
   end

   // Last flexible code is the generated clock
   always_comb begin
      flex_drv = flex_out_i;
      flex_drv[FLEX_SIGNALS-1] = mic_clk_ff; // R4
   end

   // Pad routing with special functions first
   always_comb begin
      int code;
      int b;
      code        = 0;
      b           = -1;
      nxt_out     = '0;
      nxt_oe      = '0;
      nxt_pu      = '0;
      nxt_pd      = '0;
      nxt_ana     = '0;
      nxt_flex_in = '0;
      nxt_din     = 1'b0;
      nxt_mode    = 1'b0;
      nxt_tck     = 1'b0;
      nxt_row     = '0;
      for (int s = 0; s < PAD_SLOTS; s++) begin
         code = int'(pad_sel_i[s*SEL_WIDTH +: SEL_WIDTH]);
         b    = slot_to_bit(s);
         if (s == TEST_MODE_PAD) begin
            code = 0; // R3
         end else if (dbg_active && s <= DBG_CLK_PAD) begin
            if (s == DBG_DOUT_PAD) begin // R9
               nxt_out[s] = dbg_dout_i;
               nxt_oe[s]  = dbg_dout_oe_i;
            end
            if (s == DBG_DIN_PAD) nxt_din = pad_in_i[s];
            if (s == DBG_MODE_PAD) nxt_mode = pad_in_i[s];
            if (s == DBG_CLK_PAD) nxt_tck = pad_in_i[s];
         end else if (analog_en_i && is_analog_pad(s)) begin
            nxt_ana[s] = 1'b1; // R6
         end else if (kscan_en_i && b >= 0) begin
            if (b % 2 == 1) begin // R2
               nxt_out[s] = key_matrix_column_output_i[b];
               nxt_oe[s]  = 1'b1;
            end else begin
               nxt_row[b] = pad_in_i[s];
            end
         end else if (gpio_en_i && b >= 0) begin
            nxt_out[s] = gpio_data_out_i[b]; // R10
            nxt_oe[s]  = gpio_dir_out_i[b]; // R11
         end else if (code != 0 && code <= FLEX_SIGNALS) begin
            nxt_out[s] = flex_drv[code-1]; // R1
            nxt_oe[s]  = flex_oe_i[code-1];
            nxt_flex_in[code-1] = pad_in_i[s]; // R14
         end else if (b >= 0) begin
            nxt_out[s] = gpio_data_out_i[b]; // R10
            nxt_oe[s]  = gpio_dir_out_i[b];
         end
         if (b >= 0 && !nxt_ana[s]) begin
            nxt_pu[s] = gpio_pull_en_i[b] & gpio_pull_up_i[b]; // R13
            nxt_pd[s] = gpio_pull_en_i[b] & ~gpio_pull_up_i[b];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_ff     <= '0;
         oe_ff      <= '0;
         pu_ff      <= '0;
         pd_ff      <= '0;
         ana_ff     <= '0;
         flex_in_ff <= '0;
         din_ff     <= 1'b0;
         mode_ff    <= 1'b0;
         tck_ff     <= 1'b0;
         row_ff     <= '0;
         irq_ff     <= '0;
         wake_ff    <= 1'b0;
         mic_cnt_ff <= '0;
         mic_clk_ff <= 1'b0;
      end else begin
         out_ff     <= nxt_out;
         oe_ff      <= nxt_oe;
         pu_ff      <= nxt_pu;
         pd_ff      <= nxt_pd;
         ana_ff     <= nxt_ana;
         flex_in_ff <= nxt_flex_in;
         din_ff     <= nxt_din;
         mode_ff    <= nxt_mode;
         tck_ff     <= nxt_tck;
         row_ff     <= nxt_row;
         irq_ff     <= nxt_irq;
         wake_ff    <= nxt_wake;
         mic_cnt_ff <= nxt_mic_cnt;
         mic_clk_ff <= nxt_mic_clk;
      end
   end

   assign pad_out_o              = out_ff;
   assign pad_oe_o               = oe_ff;
   assign pad_pull_up_o          = pu_ff;
   assign pad_pull_dn_o          = pd_ff;
   assign pad_analog_o           = ana_ff;
   assign flex_in_o              = flex_in_ff;
   assign dbg_din_o              = din_ff;
   assign dbg_mode_o             = mode_ff;
   assign dbg_clk_o              = tck_ff;
   assign key_matrix_row_input_o = row_ff;
   assign gpio_irq_status_o      = irq_ff;
   assign wake_o                 = wake_ff;
   assign test_mode_o            = test_mode_pad_i;
   assign adc_line_en_o = analog_en_i ? ADC_LINE_MASK : '0; // R7
   assign pga_line_en_o = analog_en_i ? PGA_LINE_MASK : '0; // R8

   AST_PAD8_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !pad_oe_o[TEST_MODE_PAD] && !pad_analog_o[TEST_MODE_PAD]) // R3
      else $error("test mode pad driven");

   AST_ANA_PADS: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(analog_en_i) && !dbg_en_i |=> pad_analog_o[ANA_LO_FIRST]
      && pad_analog_o[ANA_HI_LAST] && !pad_oe_o[ANA_LO_FIRST]) // R6
      else $error("analog pads not connected");

   AST_ADC_LINES: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      analog_en_i |-> adc_line_en_o[9] && adc_line_en_o[0]
      && !adc_line_en_o[7]) // R7
      else $error("converter lines wrong");

   AST_PGA_LINES: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      analog_en_i |-> pga_line_en_o[7] && pga_line_en_o[8]
      && !pga_line_en_o[0]) // R8
      else $error("amplifier lines wrong");

   AST_DBG_DOUT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      dbg_en_i ##1 dbg_en_i |-> pad_out_o[DBG_DOUT_PAD]
      == $past(dbg_dout_i)) // R9
      else $error("debug data out not on pad 0");

   AST_DEFAULT_DBG: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !(gpio_en_i | kscan_en_i | analog_en_i) |=>
      dbg_clk_o == $past(pad_in_i[DBG_CLK_PAD])) // R5
      else $error("default debug clock missing");

   AST_GPIO_DIR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      gpio_en_i && !dbg_en_i && !kscan_en_i && !analog_en_i |=>
      pad_oe_o[34] == $past(gpio_dir_out_i[22])) // R11
      else $error("gpio direction not applied");

   AST_IRQ_STICKY: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      gpio_irq_mode_i[11:10] == EDGE_RISE && deb_rise[5] |=>
      gpio_irq_status_o[5]) // R12
      else $error("interrupt flag lost");

   AST_SPECIAL_WINS: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      dbg_en_i |=> flex_in_o == '0 || $past(pad_sel_i[5:0]) == SEL_NONE
      || !$past(flex_in_o[0])) // R14
      else $error("flexible selection overrode debug pad");

   AST_PULL_EXCL: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (pad_pull_up_o & pad_pull_dn_o) == '0) // R13
      else $error("pull up and down together");

endmodule

// [pkg/pad_mux_pkg.sv]
// Constants, types and helpers shared by the pad multiplexer and gpio port.
// Assumes a single 200 MHz system clock domain.
package pad_mux_pkg;

   // Pad slots 0..34; slot 8 is the test mode pad and is never routed
   localparam int  PAD_SLOTS      = 35;
   localparam int  PAD_COUNT      = 34;
   localparam int  TEST_MODE_PAD  = 8;
   localparam int  GPIO_WIDTH     = 23;
   localparam int  IRQ_PINS       = 18;

   // Fixed debug test port pads
   localparam int  DBG_DOUT_PAD   = 0;
   localparam int  DBG_DIN_PAD    = 1;
   localparam int  DBG_MODE_PAD   = 2;
   localparam int  DBG_CLK_PAD    = 3;

   // Analog pad ranges and analog line numbers
   localparam int  ANA_LO_FIRST   = 11;
   localparam int  ANA_LO_LAST    = 15;
   localparam int  ANA_HI_FIRST   = 18;
   localparam int  ANA_HI_LAST    = 20;
   localparam int  ANA_LINES      = 10;
   localparam logic [9:0] ADC_LINE_MASK = 10'h21F;
   localparam logic [9:0] PGA_LINE_MASK = 10'h180;

   // Flexible signals: i2c 2x2, uart 2x2, pwm 6, spi 2x4, qdec 3,
   // i2s 4, clock 1, dmic 1 -> 31, code 0 means unselected
   localparam int  FLEX_SIGNALS   = 31;
   localparam int  SEL_WIDTH      = 6;
   localparam logic [5:0] SEL_NONE = 6'h00;

   // Clock output: 200 MHz / 1.28 MHz is not integral; nearest divider
   localparam real SYS_CLK_MHZ    = 200.0;
   localparam real MIC_CLK_MHZ    = 1.28;
   localparam int  MIC_HALF_DIV   =
      int'(SYS_CLK_MHZ / (2.0 * MIC_CLK_MHZ));

   // Debounce hold time
   localparam real DEBOUNCE_US    = 1.0;
   localparam int  DEBOUNCE_CYC   = int'(DEBOUNCE_US * SYS_CLK_MHZ);
   localparam int  DEB_CNT_W      = 8;

   // Wake and interrupt edge encoding
   typedef enum logic [1:0] {
      EDGE_OFF  = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_mode_type;

   // Pad slot to gpio bit (-1 where no bit)
   function automatic int slot_to_bit(input int slot);
      int r;
      r = -1;
      if (slot <= 3) r = slot;
      else if (slot == 7) r = 4;
      else if (slot == 9) r = 5;
      else if (slot == 10) r = 6;
      else if (slot == 11) r = 7;
      else if (slot == 14) r = 8;
      else if (slot == 15) r = 9;
      else if (slot == 16) r = 10;
      else if (slot == 17) r = 11;
      else if (slot == 18) r = 12;
      else if (slot == 20) r = 13;
      else if (slot == 23) r = 14;
      else if (slot == 24) r = 15;
      else if (slot == 25) r = 16;
      else if (slot == 26) r = 17;
      else if (slot == 27) r = 18;
      else if (slot >= 31) r = slot - 12;
      return r;
   endfunction

   // True for the pads that go analog
   function automatic logic is_analog_pad(input int slot);
      return (slot >= ANA_LO_FIRST && slot <= ANA_LO_LAST) ||
             (slot >= ANA_HI_FIRST && slot <= ANA_HI_LAST);
   endfunction

endpackage

// [rtl/gpio_debounce.sv]
// One debounced, edge-detected gpio input bit.
// Assumes the pad level is already synchronous to sys_clk_i.
`timescale 1ns/10ps
module gpio_debounce
   import pad_mux_pkg::*;
#(
   parameter int HOLD_CYC = DEBOUNCE_CYC
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic deb_en_i,
   input  wire logic raw_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);

   logic [DEB_CNT_W-1:0] cnt_ff;
   logic [DEB_CNT_W-1:0] nxt_cnt;
   logic                 level_ff;
   logic                 nxt_level;
   logic                 prev_ff;
   logic                 nxt_prev;
   logic                 armed_ff;

   always_comb begin
      nxt_cnt   = '0;
      nxt_level = level_ff;
      // First load after reset sets no edge
      nxt_prev  = armed_ff ? level_ff : nxt_level;
      if (!deb_en_i) begin
         nxt_level = raw_i;
      end else if (raw_i != level_ff) begin
         if (cnt_ff == DEB_CNT_W'(HOLD_CYC - 1)) begin
            nxt_level = raw_i;
         end else begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
      if (!armed_ff) begin
         nxt_prev = nxt_level;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff   <= '0;
         level_ff <= 1'b0;
         prev_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         cnt_ff   <= nxt_cnt;
         level_ff <= nxt_level;
         prev_ff  <= nxt_prev;
         armed_ff <= 1'b1;
      end
   end

   assign level_o = level_ff;
   assign rise_o  = level_ff & ~prev_ff;
   assign fall_o  = ~level_ff & prev_ff;

endmodule

// [verification/pad_world_model.sv]
// Pad world model: resolves each pad level seen by the multiplexer.
// Assumes outside drivers are set by the bench away from the clock edge.
`timescale 1ns/10ps
module pad_world_model
   import pad_mux_pkg::*;
(
   input  wire logic                 sys_clk_i,
   input  wire logic [PAD_SLOTS-1:0] pad_out_i,
   input  wire logic [PAD_SLOTS-1:0] pad_oe_i,
   input  wire logic [PAD_SLOTS-1:0] pad_pull_up_i,
   input  wire logic [PAD_SLOTS-1:0] pad_pull_dn_i,
   input  wire logic [PAD_SLOTS-1:0] ext_drive_i,
   input  wire logic [PAD_SLOTS-1:0] ext_val_i,
   output logic      [PAD_SLOTS-1:0] pad_in_o
);
   logic [PAD_SLOTS-1:0] float_ff = '0;

   // Undriven, unpulled pads wander every cycle
   always_ff @(posedge sys_clk_i) begin
      float_ff <= ~float_ff;
   end

   always_comb begin
      for (int i = 0; i < PAD_SLOTS; i++) begin
         if (pad_oe_i[i]) pad_in_o[i] = pad_out_i[i];
         else if (ext_drive_i[i]) pad_in_o[i] = ext_val_i[i];
         else if (pad_pull_up_i[i]) pad_in_o[i] = 1'h1;
         else if (pad_pull_dn_i[i]) pad_in_o[i] = 1'h0;
         else pad_in_o[i] = float_ff[i];
      end
   end
endmodule

// [verification/pad_mux_and_gpio_port_tb_top.sv]
// Self-checking bench for the pad multiplexer and gpio port.
// Assumes the pad world model resolves pads; debounce hold shortened to 4.
`timescale 1ns/10ps
module pad_mux_and_gpio_port_tb_top;
   import pad_mux_pkg::*;
   localparam int HOLD = 4;
   localparam int GSLOT [GPIO_WIDTH] = '{0, 1, 2, 3, 7, 9, 10, 11, 14, 15,
      16, 17, 18, 20, 23, 24, 25, 26, 27, 31, 32, 33, 34};
   typedef struct {int kind; int idx; logic [15:0] exp;} note_type;
   string knm [15] = '{"pad_out", "pad_oe", "flex_in", "gpio_in", "dbg_in",
      "adc_en", "pga_en", "pad_analog", "pull_up", "pull_dn", "row_in",
      "irq", "wake_cnt", "test_mode", "idle"};
   note_type q [$];
   event chk_ev;
   int fail_count = 0, cmp_count = 0, seed = 73, cyc = 0, wake_cnt = 0;
   int s, e;
   logic [31:0] v, w;
   logic clk = 1'h0;
   logic rst_b, tm_pad, tm, dbg_en, ana_en, gpio_en, ks_en, mic_en;
   logic dbg_do, dbg_oe, dbg_din, dbg_mode, dbg_clk, wake;
   logic [PAD_SLOTS-1:0] pad_in, pad_out, pad_oe, pu, pd, pad_ana, xdrv, xval;
   logic [PAD_SLOTS*SEL_WIDTH-1:0] sel;
   logic [FLEX_SIGNALS-1:0] f_out, f_oe, f_in;
   logic [GPIO_WIDTH-1:0] col, row, dir, dout, din, pen, pup, deb;
   logic [2*GPIO_WIDTH-1:0] wmode;
   logic [2*IRQ_PINS-1:0] imode;
   logic [IRQ_PINS-1:0] iclr, ist;
   logic [ANA_LINES-1:0] adc, pga;

   always #2.5 clk = ~clk;

   pad_multiplexer #(.HOLD_CYC(HOLD)) uut (
      .sys_clk_i(clk), .rst_b_i(rst_b), .pad_in_i(pad_in),
      .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pull_up_o(pu),
      .pad_pull_dn_o(pd), .pad_analog_o(pad_ana), .test_mode_pad_i(tm_pad),
      .test_mode_o(tm), .pad_sel_i(sel), .dbg_en_i(dbg_en),
      .analog_en_i(ana_en), .gpio_en_i(gpio_en), .kscan_en_i(ks_en),
      .flex_out_i(f_out), .flex_oe_i(f_oe), .flex_in_o(f_in),
      .mic_clk_en_i(mic_en), .dbg_dout_i(dbg_do), .dbg_dout_oe_i(dbg_oe),
      .dbg_din_o(dbg_din), .dbg_mode_o(dbg_mode), .dbg_clk_o(dbg_clk),
      .key_matrix_column_output_i(col), .key_matrix_row_input_o(row),
      .adc_line_en_o(adc), .pga_line_en_o(pga), .gpio_dir_out_i(dir),
      .gpio_data_out_i(dout), .gpio_data_in_o(din), .gpio_pull_en_i(pen),
      .gpio_pull_up_i(pup), .gpio_deb_en_i(deb), .gpio_wake_mode_i(wmode),
      .wake_o(wake), .gpio_irq_mode_i(imode), .gpio_irq_clr_i(iclr),
      .gpio_irq_status_o(ist));

   pad_world_model pads (
      .sys_clk_i(clk), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
      .pad_pull_up_i(pu), .pad_pull_dn_i(pd), .ext_drive_i(xdrv),
      .ext_val_i(xval), .pad_in_o(pad_in));

   function automatic logic [15:0] obs(input int k, input int i);
      logic [15:0] r;
      r = 16'h0000;
      case (k)
         0: r[0] = pad_out[i];
         1: r[0] = pad_oe[i];
         2: r[0] = f_in[i];
         3: r[0] = din[i];
         4: r[2:0] = {dbg_din, dbg_mode, dbg_clk};
         5: r[9:0] = adc;
         6: r[9:0] = pga;
         7: r[0] = pad_ana[i];
         8: r[0] = pu[i];
         9: r[0] = pd[i];
         10: r[0] = row[i];
         11: r[0] = ist[i];
         12: r = wake_cnt[15:0];
         13: r[0] = tm;
         default: r[3:0] = {|pad_oe, |pad_out, |ist, wake};
      endcase
      return r;
   endfunction

   task automatic expect_val(input int k, input int i, input logic [15:0] x);
      q.push_back('{k, i, x});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
      -> chk_ev;
      #1;
   endtask

   task automatic set_sel(input int slot, input logic [5:0] c);
      sel[slot*SEL_WIDTH +: SEL_WIDTH] = c;
   endtask

   task automatic compare(input note_type n);
      logic [15:0] got;
      got = obs(n.kind, n.idx);
      cmp_count++;
      if (got !== n.exp) begin
         fail_count++;
         $display("BAD %s[%0d] expected %h seen %h", knm[n.kind], n.idx,
                  n.exp, got);
      end
   endtask

   initial begin
      forever begin
         @(chk_ev);
         while (q.size() > 0) compare(q.pop_front());
      end
   end

   always @(posedge clk) begin
      if (wake === 1'h1) wake_cnt++;
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      {rst_b, tm_pad, dbg_en, ana_en, gpio_en, ks_en, mic_en} = 7'h00;
      {dbg_do, dbg_oe, xdrv, xval, sel, f_out, f_oe, col} = '0;
      {dir, dout, pen, pup, deb, wmode, imode, iclr} = '0;
      expect_val(14, 0, 16'h0000);
      settle(1);
      @(posedge clk);
      @(negedge clk);
      rst_b = 1'h1;
      $display("test reset done");
      // Default mode: debug port owns pads 0-3 over a flexible code
      v = $random(seed);
      {dbg_do, dbg_oe, f_oe[0], tm_pad} = 4'hF;
      set_sel(0, 6'h01);
      xdrv[3:1] = 3'h7;
      xval[3:1] = v[2:0];
      expect_val(0, 0, 16'h0001);
      expect_val(1, 0, 16'h0001);
      expect_val(4, 0, {13'h0, v[0], v[1], v[2]});
      expect_val(13, 0, 16'h0001);
      settle(3);
      {dbg_en, gpio_en} = 2'h3;
      expect_val(0, 0, 16'h0001);
      expect_val(1, 0, 16'h0001);
      settle(3);
      {dbg_en, gpio_en} = 2'h0;
      $display("test debug done");
      {dbg_oe, xdrv, sel} = '0;
      for (int c = 1; c <= FLEX_SIGNALS; c++) begin
         v = $random(seed);
         s = 4 + ({v} % 31);
         if (s == 8) s = 9;
         sel = '0;
         set_sel(s, c[5:0]);
         set_sel(8, c[5:0]);
         f_oe = '0;
         if (c < FLEX_SIGNALS) begin
            f_out[c-1] = v[8];
            f_oe[c-1] = 1'h1;
            expect_val(0, s, {15'h0, v[8]});
            expect_val(1, s, 16'h0001);
            expect_val(1, 8, 16'h0000);
            settle(3);
            f_oe = '0;
         end
         xdrv[s] = 1'h1;
         xval[s] = v[9];
         expect_val(2, c - 1, {15'h0, v[9]});
         settle(3);
         xdrv = '0;
      end
      $display("test flexible done");
      ana_en = 1'h1;
      sel = '0;
      set_sel(11, 6'h01);
      f_out[0] = 1'h1;
      f_oe[0] = 1'h1;
      expect_val(5, 0, 16'h021F);
      expect_val(6, 0, 16'h0180);
      expect_val(1, 11, 16'h0000);
      for (int p = 0; p < PAD_SLOTS; p++)
         expect_val(7, p, ((p >= 11 && p <= 15) || (p >= 18 && p <= 20)));
      settle(3);
      {ana_en, f_oe, sel} = '0;
      expect_val(5, 0, 16'h0000);
      expect_val(6, 0, 16'h0000);
      settle(3);
      $display("test analog done");
      gpio_en = 1'h1;
      for (int r = 0; r < 2; r++) begin
         v = $random(seed);
         w = $random(seed);
         {dir, dout, pen} = {v[22:0], w[22:0], v[31:23], w[31:18]};
         pup = v[22:0] ^ w[31:9];
         for (int b = 0; b < GPIO_WIDTH; b++) begin
            s = GSLOT[b];
            xdrv[s] = ~dir[b];
            xval[s] = w[b];
            expect_val(8, s, {15'h0, pen[b] & pup[b]});
            expect_val(9, s, {15'h0, pen[b] & ~pup[b]});
            if (dir[b]) begin
               expect_val(0, s, {15'h0, dout[b]});
               expect_val(1, s, 16'h0001);
            end
            else expect_val(3, b, {15'h0, w[b]});
         end
         settle(3);
      end
      $display("test gpio done");
      {dir, pen, xval} = '0;
      for (int b = 0; b < GPIO_WIDTH; b++) xdrv[GSLOT[b]] = 1'h1;
      deb[5] = 1'h1;
      wmode[11:10] = EDGE_RISE;
      imode[11:10] = EDGE_RISE;
      settle(HOLD + 4);
      wake_cnt = 0;
      xval[9] = 1'h1;
      repeat (HOLD - 2) @(negedge clk);
      xval[9] = 1'h0;
      expect_val(3, 5, 16'h0000);
      expect_val(12, 0, 16'h0000);
      expect_val(11, 5, 16'h0000);
      settle(HOLD + 4);
      xval[9] = 1'h1;
      expect_val(3, 5, 16'h0001);
      expect_val(12, 0, 16'h0001);
      expect_val(11, 5, 16'h0001);
      settle(HOLD + 4);
      iclr[5] = 1'h1;
      @(negedge clk);
      iclr[5] = 1'h0;
      expect_val(11, 5, 16'h0000);
      settle(3);
      wmode = '0;
      for (int m = 0; m < 4; m++) begin
         wmode[41:40] = m[1:0];
         settle(2);
         wake_cnt = 0;
         xval[32] = 1'h1;
         repeat (4) @(negedge clk);
         xval[32] = 1'h0;
         e = m[0] + m[1];
         expect_val(12, 0, e[15:0]);
         settle(4);
      end
      $display("test wake done");
      gpio_en = 1'h0;
      ks_en = 1'h1;
      xdrv = '0;
      v = $random(seed);
      w = $random(seed);
      col = v[22:0];
      for (int b = 0; b < GPIO_WIDTH; b++) begin
         s = GSLOT[b];
         if (b % 2) begin
            expect_val(0, s, {15'h0, v[b]});
            expect_val(1, s, 16'h0001);
         end
         else begin
            xdrv[s] = 1'h1;
            xval[s] = w[b];
            expect_val(10, b, {15'h0, w[b]});
         end
      end
      settle(3);
      $display("test key scan done");
      final_report();
   end
endmodule
